//--- hdl/can_rx_pkg.sv
// Package with register map, field layout and constants of the CAN receive block.
// Behaviour
// - Length code is four bits; 0 to 8 give byte count, 9 to 15 are invalid.
// - Length register bit 6 shows a remote request frame.
// - Length register bits 7, 5 and 4 always read zero.
// - Each receive buffer has eight readable data bytes, indexed 0 to 7.
// - Eight-bit read-only receive error count; above 127 means error passive.
// - Receive error count never causes bus-off on its own.
// - Filter low byte bit 3 selects extended-only or standard-only acceptance.
// - Filter high byte matches standard bits 10..3 or extended bits 28..21.
// - Filter low byte bits 7..5 and 1..0 hold id bits; bits 4 and 2 read zero.
// - Mask high byte covers standard bits 10..3 or extended bits 28..21.
// - Mask low byte bits 7..5 and 1..0 hold mask bits; bits 4..2 read zero.
// - Buffer keeps extended id bits 15..0; filters and masks hold bits 15..0.
// - Device sets full flag on store; software clears it after reading.
// - Mode 00 all valid, 01 standard, 10 extended, 11 all including errored.
package can_rx_pkg;
    localparam int NUM_BUF = 2;
    localparam int NUM_FILT = 2;
    localparam int NUM_DATA = 8;
    localparam logic [3:0] LEN_MAX = 4'h8;
    localparam logic [7:0] REC_PASSIVE_LIMIT = 8'h7F;
    // Byte offsets, one aligned word each.
    localparam logic [11:0] OFS_BUF_BASE = 12'h000;
    localparam logic [11:0] OFS_BUF_STRIDE = 12'h040;
    localparam logic [5:0] OFS_STD_HIGH = 6'h00;
    localparam logic [5:0] OFS_STD_LOW = 6'h04;
    localparam logic [5:0] OFS_EXT_HIGH = 6'h08;
    localparam logic [5:0] OFS_EXT_LOW = 6'h0C;
    localparam logic [5:0] OFS_LENGTH = 6'h10;
    localparam logic [5:0] OFS_CTRL = 6'h14;
    localparam logic [5:0] OFS_DATA0 = 6'h20;
    localparam logic [11:0] OFS_FILT_BASE = 12'h100;
    localparam logic [11:0] OFS_MASK_BASE = 12'h180;
    localparam logic [11:0] OFS_ID_STRIDE = 12'h010;
    localparam logic [11:0] OFS_REC = 12'h200;
    localparam logic [11:0] OFS_STATUS = 12'h204;
    localparam logic [11:0] OFS_INT_STAT = 12'h208;
    localparam logic [11:0] OFS_INT_MASK = 12'h20C;
    // Field positions.
    localparam int LEN_RTR_BIT = 6;
    localparam int SEL_EXT_BIT = 3;
    localparam int CTRL_FULL_BIT = 7;
    localparam logic [7:0] STD_LOW_KEEP = 8'hEB;
    localparam logic [7:0] MASK_LOW_KEEP = 8'hE3;
    localparam logic [7:0] LEN_KEEP = 8'h4F;
    localparam logic [1:0] MODE_ALL_VALID = 2'h0;
    localparam logic [1:0] MODE_STD_ONLY = 2'h1;
    localparam logic [1:0] MODE_EXT_ONLY = 2'h2;
    localparam logic [1:0] MODE_ALL = 2'h3;
    // Interrupt status bits: frame stored in buffer 0, 1; frame dropped.
    localparam int INT_W = 3;
    localparam int INT_DROP_BIT = 2;
endpackage

//--- hdl/can_id_match.sv
// One acceptance filter with its mask checked against a received identifier.
`timescale 1ns/100ps
`default_nettype none
module can_id_match
    import can_rx_pkg::*;
(
    input wire logic [28:0] rx_id,
    input wire logic rx_ext,
    input wire logic [7:0] f_std_high,
    input wire logic [7:0] f_std_low,
    input wire logic [7:0] f_ext_high,
    input wire logic [7:0] f_ext_low,
    input wire logic [7:0] m_std_high,
    input wire logic [7:0] m_std_low,
    input wire logic [7:0] m_ext_high,
    input wire logic [7:0] m_ext_low,
    output logic hit
);
    logic [28:0] fid;
    logic [28:0] mid;
    logic [28:0] cmp;
    logic fsel;
    // Filter and mask bytes are laid out as one 29-bit identifier.
    always_comb
    begin
        fsel = f_std_low[SEL_EXT_BIT];
        fid = {f_std_high, f_std_low[7:5], f_std_low[1:0],
               f_ext_high, f_ext_low};
        mid = {m_std_high, m_std_low[7:5], m_std_low[1:0],
               m_ext_high, m_ext_low};
        if (!fsel)
        begin
            // Standard identifiers sit in bits 28..18.
            mid[17:0] = '0;
        end
        cmp = (rx_id ^ fid) & mid;
        hit = (fsel == rx_ext) && (cmp == '0);
    end
endmodule // can_id_match
`default_nettype wire

//--- hdl/can_rx_err_count.sv
// Receive error counter with error-passive indication.
`timescale 1ns/100ps
`default_nettype none
module can_rx_err_count
    import can_rx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic err_inc1,
    input wire logic err_inc8,
    input wire logic ok_dec,
    output logic [7:0] count,
    output logic passive
);
    typedef struct packed {
        logic [7:0] cnt;
        logic pas;
    } st_t;
    st_t s_r;
    st_t s_nxt;
    logic [8:0] sum;
    // Saturating count; it only reports passive, never bus-off.
    always_comb
    begin
        s_nxt = s_r;
        sum = {1'b0, s_r.cnt};
        if (err_inc8)
            sum = sum + 9'h008;
        else if (err_inc1)
            sum = sum + 9'h001;
        else if (ok_dec && s_r.cnt != 8'h00)
            sum = sum - 9'h001;
        s_nxt.cnt = sum[8] ? 8'hFF : sum[7:0];
        s_nxt.pas = s_nxt.cnt > REC_PASSIVE_LIMIT;
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
    assign count = s_r.cnt;
    assign passive = s_r.pas;
endmodule // can_rx_err_count
`default_nettype wire

//--- hdl/can_rx_buffer_acceptance_filter.sv
// Receive buffers, acceptance filters and AHB-Lite registers of a CAN receiver.
`timescale 1ns/100ps
`default_nettype none
module can_rx_buffer_acceptance_filter
    import can_rx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic frame_valid,
    input wire logic frame_error,
    input wire logic [28:0] frame_id,
    input wire logic frame_ext,
    input wire logic frame_rtr,
    input wire logic [3:0] frame_len,
    input wire logic [63:0] frame_data,
    input wire logic rec_inc1,
    input wire logic rec_inc8,
    input wire logic rec_dec,
    output logic error_passive,
    output logic irq
);
    typedef struct packed {
        logic [7:0] std_high;
        logic [7:0] std_low;
        logic [7:0] ext_high;
        logic [7:0] ext_low;
        logic [7:0] length;
        logic [NUM_DATA-1:0][7:0] data;
        logic full;
        logic [1:0] mode;
        logic hit;
    } buf_t;
    typedef struct packed {
        logic [7:0] std_high;
        logic [7:0] std_low;
        logic [7:0] ext_high;
        logic [7:0] ext_low;
    } idreg_t;
    typedef struct packed {
        buf_t [NUM_BUF-1:0] rb;
        idreg_t [NUM_FILT-1:0] filt;
        idreg_t [NUM_FILT-1:0] mask;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_mask;
        logic wr_pend;
        logic [11:0] wr_addr;
        logic [31:0] rdata;
        logic irq;
        logic passive;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic [NUM_FILT-1:0] hit;
    logic [7:0] rec_count;
    logic rec_passive;

    // Filter n steers buffer n; each compares against the incoming frame.
    genvar g;
    generate
        for (g = 0; g < NUM_FILT; g++)
        begin : g_match
            can_id_match u_match (
                .rx_id(frame_id),
                .rx_ext(frame_ext),
                .f_std_high(s_r.filt[g].std_high),
                .f_std_low(s_r.filt[g].std_low),
                .f_ext_high(s_r.filt[g].ext_high),
                .f_ext_low(s_r.filt[g].ext_low),
                .m_std_high(s_r.mask[g].std_high),
                .m_std_low(s_r.mask[g].std_low),
                .m_ext_high(s_r.mask[g].ext_high),
                .m_ext_low(s_r.mask[g].ext_low),
                .hit(hit[g])
            );
        end
    endgenerate

    can_rx_err_count u_rec (
        .hclk(hclk),
        .hresetn(hresetn),
        .err_inc1(rec_inc1),
        .err_inc8(rec_inc8),
        .ok_dec(rec_dec),
        .count(rec_count),
        .passive(rec_passive)
    );

    // Decide whether a buffer takes the frame under its mode setting.
    function automatic logic mode_ok(input logic [1:0] m, input logic ext,
                                     input logic err);
        logic ok;
        ok = 1'b0;
        unique case (m)
            MODE_ALL_VALID: ok = !err;
            MODE_STD_ONLY: ok = !err && !ext;
            MODE_EXT_ONLY: ok = !err && ext;
            MODE_ALL: ok = 1'b1;
        endcase
        return ok;
    endfunction

    // Read value of the register at a word address.
    function automatic logic [31:0] read_reg(input state_t s,
                                             input logic [11:0] a);
        logic [31:0] v;
        logic [5:0] sub;
        int b;
        v = '0;
        sub = a[5:0];
        for (b = 0; b < NUM_BUF; b++)
        begin
            if (a[11:6] == 6'((OFS_BUF_BASE + OFS_BUF_STRIDE * b) >> 6))
            begin
                if (sub == OFS_STD_HIGH)
                    v[7:0] = s.rb[b].std_high;
                if (sub == OFS_STD_LOW)
                    v[7:0] = s.rb[b].std_low;
                if (sub == OFS_EXT_HIGH)
                    v[7:0] = s.rb[b].ext_high;
                if (sub == OFS_EXT_LOW)
                    v[7:0] = s.rb[b].ext_low;
                if (sub == OFS_LENGTH)
                    v[7:0] = s.rb[b].length & LEN_KEEP;
                if (sub == OFS_CTRL)
                    v[7:0] = {s.rb[b].full, s.rb[b].mode, 4'h0,
                              s.rb[b].hit};
                // The upper half of a buffer's window holds the data bytes.
                if (sub[5])
                    v[7:0] = s.rb[b].data[sub[4:2]];
            end
        end
        for (b = 0; b < NUM_FILT; b++)
        begin
            if (a[11:4] == 8'((OFS_FILT_BASE + OFS_ID_STRIDE * b) >> 4))
                v[7:0] = s.filt[b][8 * (3 - int'(a[3:2])) +: 8];
            if (a[11:4] == 8'((OFS_MASK_BASE + OFS_ID_STRIDE * b) >> 4))
                v[7:0] = s.mask[b][8 * (3 - int'(a[3:2])) +: 8];
        end
        if (a == OFS_REC)
            v[7:0] = rec_count;
        if (a == OFS_STATUS)
            v[0] = rec_passive;
        if (a == OFS_INT_STAT)
            v[INT_W-1:0] = s.int_stat;
        if (a == OFS_INT_MASK)
            v[INT_W-1:0] = s.int_mask;
        return v;
    endfunction

    logic addr_phase;
    logic [INT_W-1:0] evt;
    logic stored;

    // Bus decode, write data phase, frame storage and interrupts.
    always_comb
    begin
        s_nxt = s_r;
        evt = '0;
        stored = 1'b0;
        addr_phase = hsel && hready && htrans[1];
        if (s_r.wr_pend)
        begin
            for (int b = 0; b < NUM_BUF; b++)
            begin
                if (s_r.wr_addr[11:6] ==
                    6'((OFS_BUF_BASE + OFS_BUF_STRIDE * b) >> 6))
                begin
                    unique case (s_r.wr_addr[5:0])
                        OFS_STD_HIGH: s_nxt.rb[b].std_high = hwdata[7:0];
                        OFS_STD_LOW: s_nxt.rb[b].std_low = hwdata[7:0];
                        OFS_EXT_HIGH: s_nxt.rb[b].ext_high = hwdata[7:0];
                        OFS_EXT_LOW: s_nxt.rb[b].ext_low = hwdata[7:0];
                        OFS_LENGTH: s_nxt.rb[b].length =
                            hwdata[7:0] & LEN_KEEP;
                        OFS_CTRL:
                        begin
                            s_nxt.rb[b].mode = hwdata[6:5];
                            if (!hwdata[CTRL_FULL_BIT])
                                s_nxt.rb[b].full = 1'b0;
                        end
                        default:
                        begin
                            if (s_r.wr_addr[5])
                                s_nxt.rb[b].data[s_r.wr_addr[4:2]] =
                                    hwdata[7:0];
                        end
                    endcase
                end
            end
            for (int b = 0; b < NUM_FILT; b++)
            begin
                if (s_r.wr_addr[11:4] ==
                    8'((OFS_FILT_BASE + OFS_ID_STRIDE * b) >> 4))
                begin
                    s_nxt.filt[b][8 * (3 - int'(s_r.wr_addr[3:2])) +: 8] =
                        hwdata[7:0];
                    s_nxt.filt[b].std_low = s_nxt.filt[b].std_low
                        & STD_LOW_KEEP;
                end
                if (s_r.wr_addr[11:4] ==
                    8'((OFS_MASK_BASE + OFS_ID_STRIDE * b) >> 4))
                begin
                    s_nxt.mask[b][8 * (3 - int'(s_r.wr_addr[3:2])) +: 8] =
                        hwdata[7:0];
                    s_nxt.mask[b].std_low = s_nxt.mask[b].std_low
                        & MASK_LOW_KEEP;
                end
            end
            if (s_r.wr_addr == OFS_INT_STAT)
                s_nxt.int_stat = s_r.int_stat & ~hwdata[INT_W-1:0];
            if (s_r.wr_addr == OFS_INT_MASK)
                s_nxt.int_mask = hwdata[INT_W-1:0];
        end
        // A finished frame goes to the first free buffer whose filter hits and whose mode accepts it.
        if (frame_valid)
        begin
            for (int b = 0; b < NUM_BUF; b++)
            begin
                if (!stored && hit[b] && !s_r.rb[b].full
                    && mode_ok(s_r.rb[b].mode, frame_ext, frame_error))
                begin
                    stored = 1'b1;
                    s_nxt.rb[b].std_high = frame_id[28:21];
                    s_nxt.rb[b].std_low = {frame_id[20:18], 1'b0,
                        frame_ext, 1'b0, frame_id[17:16]};
                    s_nxt.rb[b].ext_high = frame_id[15:8];
                    s_nxt.rb[b].ext_low = frame_id[7:0];
                    s_nxt.rb[b].length = {1'b0, frame_rtr, 2'b00,
                        frame_len};
                    for (int d = 0; d < NUM_DATA; d++)
                        s_nxt.rb[b].data[d] = frame_data[8 * d +: 8];
                    s_nxt.rb[b].hit = 1'b1;
                    // Contents and full flag land on the same edge.
                    s_nxt.rb[b].full = 1'b1;
                    evt[b] = 1'b1;
                end
            end
            if (!stored)
                evt[INT_DROP_BIT] = 1'b1;
        end
        s_nxt.int_stat = s_nxt.int_stat | evt; // set wins over clear
        s_nxt.wr_pend = addr_phase && hwrite;
        s_nxt.wr_addr = {haddr[11:2], 2'b00};
        if (addr_phase && !hwrite)
            s_nxt.rdata = read_reg(s_nxt, {haddr[11:2], 2'b00});
        s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);
        s_nxt.passive = rec_passive;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign hrdata = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = s_r.irq;
    assign error_passive = s_r.passive;
endmodule // can_rx_buffer_acceptance_filter
`default_nettype wire

//--- test/can_rx_checker.sv
// Concurrent checks on the bus and status ports of the CAN receive block.
`timescale 1ns/100ps
`default_nettype none
module can_rx_checker
    import can_rx_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rec_inc1,
    input wire logic rec_inc8,
    input wire logic rec_dec,
    input wire logic error_passive
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic rd;
    logic ev;
    // A read is taken here; its data stands at the next sample.
    assign rd = hsel && hready && htrans[1] && !hwrite;
    assign ev = rec_inc1 || rec_inc8 || rec_dec;
    ready_high_a: assert property (hreadyout)
        else $error("hreadyout dropped low");
    resp_okay_a: assert property (!hresp)
        else $error("hresp not OKAY");
    upper_zero_a: assert property (rd |-> ##1 hrdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    len_zero_a: assert property (rd &&
        haddr == OFS_BUF_BASE + OFS_BUF_STRIDE + 12'(OFS_LENGTH) |->
        ##1 hrdata[7] == 1'b0 && hrdata[5:4] == 2'h0)
        else $error("length register reserved bits set");
    filt_zero_a: assert property (rd &&
        haddr == OFS_FILT_BASE + OFS_ID_STRIDE + 12'h004 |->
        ##1 hrdata[4] == 1'b0 && hrdata[2] == 1'b0)
        else $error("filter low byte unused bits set");
    mask_zero_a: assert property (rd &&
        haddr == OFS_MASK_BASE + OFS_ID_STRIDE + 12'h004 |->
        ##1 hrdata[4:2] == 3'h0)
        else $error("mask low byte unused bits set");
    passive_level_a: assert property (rd && haddr == OFS_REC |->
        ##1 error_passive == (hrdata[7:0] > REC_PASSIVE_LIMIT))
        else $error("error passive disagrees with count");
    passive_hold_a: assert property (!$past(ev, 2) |->
        $stable(error_passive))
        else $error("error passive moved without a count event");
endmodule // can_rx_checker
bind can_rx_buffer_acceptance_filter can_rx_checker can_rx_checker_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rec_inc1(rec_inc1),
    .rec_inc8(rec_inc8), .rec_dec(rec_dec), .error_passive(error_passive));
`default_nettype wire

//--- test/can_frame_source.sv
// Behavioural protocol engine that hands received frames to the block.
`timescale 1ns/100ps
`default_nettype none
module can_frame_source (
    input wire logic hclk,
    output logic frame_valid,
    output logic frame_error,
    output logic [28:0] frame_id,
    output logic frame_ext,
    output logic frame_rtr,
    output logic [3:0] frame_len,
    output logic [63:0] frame_data,
    output logic rec_inc1,
    output logic rec_inc8,
    output logic rec_dec
);
    // Everything quiet at time zero.
    initial
    begin
        {frame_valid, frame_error, frame_id, frame_ext} = '0;
        {frame_rtr, frame_len, frame_data} = '0;
        {rec_inc8, rec_inc1, rec_dec} = 3'h0;
    end
    // One frame for one cycle; the fields are then inverted, not held.
    task automatic send(input logic [28:0] id, input logic ext, rtr, err,
        input logic [3:0] len, input logic [63:0] data);
        @(posedge hclk);
        {frame_valid, frame_id, frame_ext, frame_rtr, frame_error,
            frame_len, frame_data} <= {1'b1, id, ext, rtr, err, len, data};
        @(posedge hclk);
        {frame_valid, frame_id, frame_ext, frame_rtr, frame_error,
            frame_len, frame_data} <= {1'b0, ~{id, ext, rtr, err, len, data}};
    endtask
    // One-cycle counter event, bits ordered as add eight, add one, remove.
    task automatic pulse(input logic [2:0] k);
        @(posedge hclk);
        {rec_inc8, rec_inc1, rec_dec} <= k;
        @(posedge hclk);
        {rec_inc8, rec_inc1, rec_dec} <= 3'h0;
    endtask
endmodule // can_frame_source
`default_nettype wire

//--- test/test_can_rx_buffer_acceptance_filter.sv
// Self-checking testbench of the CAN receive buffers and filters.
`timescale 1ns/100ps
`default_nettype none
module test_can_rx_buffer_acceptance_filter
    import can_rx_pkg::*;
;
    localparam logic [11:0] F1 = OFS_FILT_BASE + OFS_ID_STRIDE;
    localparam logic [11:0] M1 = OFS_MASK_BASE + OFS_ID_STRIDE;
    localparam logic [11:0] B1 = OFS_BUF_BASE + OFS_BUF_STRIDE; // Buffer one.
    localparam logic [28:0] SID = {11'h5A3, 18'h00000};
    localparam logic [28:0] XID = 29'h0ACE1357;
    localparam logic [63:0] DAT = 64'h8877665544332211;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout, hresp, error_passive, irq;
    logic frame_valid, frame_error, frame_ext, frame_rtr;
    logic [28:0] frame_id;
    logic [3:0] frame_len;
    logic [63:0] frame_data;
    logic rec_inc1, rec_inc8, rec_dec;
    int mismatches = 0;
    int n_compared = 0;
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    can_rx_buffer_acceptance_filter can_rx_buffer_acceptance_filter_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .frame_valid(frame_valid),
        .frame_error(frame_error), .frame_id(frame_id),
        .frame_ext(frame_ext), .frame_rtr(frame_rtr),
        .frame_len(frame_len), .frame_data(frame_data),
        .rec_inc1(rec_inc1), .rec_inc8(rec_inc8), .rec_dec(rec_dec),
        .error_passive(error_passive), .irq(irq));
    can_frame_source can_frame_source_inst (
        .hclk(hclk), .frame_valid(frame_valid), .frame_error(frame_error),
        .frame_id(frame_id), .frame_ext(frame_ext), .frame_rtr(frame_rtr),
        .frame_len(frame_len), .frame_data(frame_data),
        .rec_inc1(rec_inc1), .rec_inc8(rec_inc8), .rec_dec(rec_dec));
    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One single transfer: address phase, then data phase, each held
    // until hready is seen high.
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, 24'h000000, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        q = hrdata[7:0];
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rc(input string what, input logic [11:0] a,
        input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(what, exp, q);
    endtask
    // Filter one takes id and selector; mask one is all ones but its extended low byte.
    task automatic setup(input logic [28:0] id, input logic ext,
        input logic [7:0] mlo);
        wr(F1, id[28:21]);
        wr(F1 + 12'h004, {id[20:18], 1'b0, ext, 1'b0, id[17:16]});
        wr(F1 + 12'h008, id[15:8]);
        wr(F1 + 12'h00C, id[7:0]);
        wr(M1, 8'hFF);
        wr(M1 + 12'h004, 8'hFF);
        wr(M1 + 12'h008, 8'hFF);
        wr(M1 + 12'h00C, mlo);
    endtask
    // Frees buffer one in the given mode, sends, judges take or drop.
    task automatic frame(input string what, input logic [28:0] id,
        input logic ext, err, acc, input logic [1:0] mode);
        wr(B1 + 12'h014, {1'b0, mode, 5'h00});
        wr(OFS_INT_STAT, 8'h07);
        can_frame_source_inst.send(id, ext, 1'b0, err, 4'h2, 64'h0);
        rc(what, OFS_INT_STAT, acc ? 8'h02 : 8'h04);
    endtask
    task automatic t_reset();
        rc("rec", OFS_REC, 8'h00);
        chk("irq", 8'h00, {7'h00, irq});
        wr(12'h3F0, 8'h77);
        rc("unmapped", 12'h3F0, 8'h00);
        wr(OFS_FILT_BASE, 8'hFF);
        wr(OFS_MASK_BASE, 8'hFF);
    endtask
    task automatic t_fields();
        wr(F1 + 12'h004, 8'hFF);
        rc("filter low", F1 + 12'h004, 8'hEB);
        wr(M1 + 12'h004, 8'hFF);
        rc("mask low", M1 + 12'h004, 8'hE3);
        wr(F1, 8'hA5);
        rc("filter high", F1, 8'hA5);
        wr(M1, 8'h5A);
        rc("mask high", M1, 8'h5A);
    endtask
    task automatic t_store();
        logic [7:0] q;
        setup(XID, 1'b1, 8'hFF);
        wr(OFS_INT_MASK, 8'h02);
        wr(B1 + 12'h014, {1'b0, MODE_EXT_ONLY, 5'h00});
        can_frame_source_inst.send(XID, 1'b1, 1'b1, 1'b0, 4'h8, DAT);
        bus(1'b0, B1 + 12'h014, 8'h00, q);
        chk("full", 8'h80, q & 8'h80);
        chk("irq", 8'h01, {7'h00, irq});
        rc("length", B1 + 12'h010, 8'h48);
        rc("ext low", B1 + 12'h00C, XID[7:0]);
        rc("std high", B1, XID[28:21]);
        for (int d = 0; d < NUM_DATA; d++)
            rc("data", B1 + 12'h020 + 12'(4 * d), DAT[8 * d +: 8]);
        wr(OFS_INT_STAT, 8'h02);
        repeat (2) @(posedge hclk);
        chk("irq clear", 8'h00, {7'h00, irq});
        can_frame_source_inst.send(XID, 1'b1, 1'b0, 1'b0, 4'h1, ~DAT);
        rc("full drop", OFS_INT_STAT, 8'h04);
        rc("data kept", B1 + 12'h020, 8'h11);
    endtask
    task automatic t_modes();
        wr(OFS_INT_MASK, 8'h00);
        setup(SID, 1'b0, 8'hFF);
        frame("all valid", SID, 1'b0, 1'b0, 1'b1, MODE_ALL_VALID);
        chk("irq masked", 8'h00, {7'h00, irq});
        frame("std only", SID, 1'b0, 1'b0, 1'b1, MODE_STD_ONLY);
        frame("ext only", SID, 1'b0, 1'b0, 1'b0, MODE_EXT_ONLY);
        frame("err valid", SID, 1'b0, 1'b1, 1'b0, MODE_ALL_VALID);
        frame("err all", SID, 1'b0, 1'b1, 1'b1, MODE_ALL);
        frame("ext on std", SID, 1'b1, 1'b0, 1'b0, MODE_ALL);
        setup(XID, 1'b1, 8'hFE);
        frame("mask zero", XID ^ 29'h1, 1'b1, 1'b0, 1'b1, MODE_ALL);
        frame("std on ext", XID, 1'b0, 1'b0, 1'b0, MODE_ALL);
        wr(M1 + 12'h00C, 8'hFF);
        frame("mask one", XID ^ 29'h1, 1'b1, 1'b0, 1'b0, MODE_ALL);
    endtask
    task automatic t_rec();
        repeat (16) can_frame_source_inst.pulse(3'h4);
        can_frame_source_inst.pulse(3'h1);
        repeat (3) @(posedge hclk);
        rc("rec", OFS_REC, 8'h7F);
        chk("passive", 8'h00, {7'h00, error_passive});
        can_frame_source_inst.pulse(3'h2);
        repeat (3) @(posedge hclk);
        rc("rec", OFS_REC, 8'h80);
        chk("passive", 8'h01, {7'h00, error_passive});
        repeat (20) can_frame_source_inst.pulse(3'h4);
        repeat (3) @(posedge hclk);
        rc("rec top", OFS_REC, 8'hFF);
        rc("status", OFS_STATUS, 8'h01);
    endtask
    // Main sequence after eight cycles of reset.
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_fields();
        t_store();
        t_modes();
        t_rec();
        give_verdict();
    end
    // Cuts a hang short well past the expected run length.
    initial
    begin
        #100000;
        mismatches++;
        give_verdict();
    end
endmodule // test_can_rx_buffer_acceptance_filter
`default_nettype wire
